// ### common/spc_pkg.sv
package spc_pkg;
  localparam int CLK_MHZ = 100;
  // master serial clock half period
  localparam int SCLK_HALF_NS = 60;
  localparam int HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
  localparam int WORD_W = 8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam int FIFO_DEPTH = 16;
  localparam int LINES = 4;
  // line index of each multiplexed pin
  localparam int IDX_LINE_FOUR = 0;
  localparam int IDX_LINE_FIVE = 1;
  localparam int IDX_LINE_SIX = 2;
  localparam int IDX_LINE_SEVEN = 3;
  localparam logic [3:0] PIN_GPIO_RST = 4'h0;
  localparam logic [7:0] TX_IDLE_WORD = 8'h00;
  localparam logic [3:0] LINE_OE_N_RST = 4'hF;
  localparam logic [3:0] LINE_OUT_RST = 4'h0;
  localparam logic [3:0] LINE_SYNC_RST = 4'h8;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_LOW = 2'b01,
    M_HIGH = 2'b11,
    M_FAULT = 2'b10
  } spc_mst_t;
endpackage

// ### core/spc_fifo.sv
module spc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = cnt_q != FULL_CNT;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### core/spc_port.sv
// Notes on behaviour
// - The data-in line is an input for the master and an output for the slave.
// - An unselected slave releases its data-out line to high impedance.
// - The data-out line is driven by the master and sampled by the slave.
// - The master sets each bit half a clock period before the capture edge.
// - The serial clock is driven as master and taken as input as slave.
// - As master, a low select input flags contention with another master.
// - As slave, transfers happen only while the select input is low.
// - Each of the four lines can be a general I/O with its own direction.
// - After reset all four lines carry their serial-port function.
// - The select line is never driven except as a general I/O output.
module spc_port (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CE,
  input wire logic MASTER_MODE,
  input wire logic [3:0] GPIO_SEL,
  input wire logic [3:0] GPIO_DIR,
  input wire logic [3:0] GPIO_OUT,
  output logic [3:0] GPIO_IN,
  input wire logic FAULT_CLR,
  output logic MODE_FAULT,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RX_OVERRUN,
  input wire logic [3:0] LINE_IN,
  output logic [3:0] LINE_OUT,
  output logic [3:0] LINE_OE_N
);
  logic [3:0] line_s;
  logic sclk_s, mosi_s, miso_s, ss_s;
  logic master_q, sclk_prev_q, ss_prev_q, fault_q, tx_full_q;
  logic [3:0] pin_gpio_q;
  logic [7:0] tx_q, word_in, shreg_q;
  logic [2:0] bit_q;
  logic [3:0] half_q;
  logic miso_q, overrun_q;
  spc_pkg::spc_mst_t st_q;
  logic ss_low, slv_act, slv_start, rise, fall, fault_set;
  logic half_done, mst_start, mst_last, slv_reload, tx_take;
  logic fifo_in_valid, fifo_in_ready, mst_drive;
  logic [7:0] fifo_in_data;
  logic [3:0] spi_oe_n, spi_out;

  spc_sync #(
    .W(spc_pkg::LINES),
    .RST_VAL(spc_pkg::LINE_SYNC_RST)
  ) u_sync (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .d(LINE_IN),
    .q(line_s)
  );

  assign sclk_s = line_s[spc_pkg::IDX_LINE_FOUR];
  assign mosi_s = line_s[spc_pkg::IDX_LINE_FIVE];
  assign miso_s = line_s[spc_pkg::IDX_LINE_SIX];
  assign ss_s = line_s[spc_pkg::IDX_LINE_SEVEN];
  assign GPIO_IN = line_s;

  // role and pin function
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      master_q <= 1'b0;
      pin_gpio_q <= spc_pkg::PIN_GPIO_RST;
    end else if (CE) begin
      master_q <= MASTER_MODE;
      pin_gpio_q <= GPIO_SEL;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      sclk_prev_q <= 1'b0;
      ss_prev_q <= 1'b1;
    end else if (CE) begin
      sclk_prev_q <= sclk_s;
      ss_prev_q <= ss_s;
    end
  end

  assign ss_low = !pin_gpio_q[spc_pkg::IDX_LINE_SEVEN] && !ss_s;
  assign slv_act = !master_q && ss_low;
  assign slv_start = slv_act && ss_prev_q;
  assign rise = sclk_s && !sclk_prev_q;
  assign fall = !sclk_s && sclk_prev_q;
  assign fault_set = master_q && ss_low;

  // contention flag, set wins over clear
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      fault_q <= 1'b0;
    end else if (CE) begin
      if (fault_set) begin
        fault_q <= 1'b1;
      end else if (FAULT_CLR) begin
        fault_q <= 1'b0;
      end
    end
  end

  assign MODE_FAULT = fault_q;

  // transmit holding word
  assign TX_READY = !tx_full_q;
  assign word_in = tx_full_q ? tx_q : spc_pkg::TX_IDLE_WORD;
  assign tx_take = tx_full_q && (mst_start || slv_reload || slv_start);

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      tx_full_q <= 1'b0;
      tx_q <= spc_pkg::TX_IDLE_WORD;
    end else if (CE) begin
      if (TX_VALID && !tx_full_q) begin
        tx_full_q <= 1'b1;
        tx_q <= TX_DATA;
      end else if (tx_take) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  assign half_done = half_q == spc_pkg::HALF_LAST;
  assign mst_start = (st_q == spc_pkg::M_IDLE) && master_q && tx_full_q &&
    !fault_set && !fault_q;
  assign mst_last = (st_q == spc_pkg::M_HIGH) && half_done &&
    (bit_q == spc_pkg::LAST_BIT);

  // master clock generator
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_q <= spc_pkg::M_IDLE;
      half_q <= 4'h0;
    end else if (CE) begin
      if (fault_set) begin
        st_q <= spc_pkg::M_FAULT;
        half_q <= 4'h0;
      end else begin
        case (st_q)
          spc_pkg::M_IDLE: begin
            if (mst_start) begin
              st_q <= spc_pkg::M_LOW;
              half_q <= 4'h0;
            end
          end
          spc_pkg::M_LOW: begin
            if (half_done) begin
              st_q <= spc_pkg::M_HIGH;
              half_q <= 4'h0;
            end else begin
              half_q <= half_q + 4'h1;
            end
          end
          spc_pkg::M_HIGH: begin
            if (!half_done) begin
              half_q <= half_q + 4'h1;
            end else if (bit_q != spc_pkg::LAST_BIT) begin
              st_q <= spc_pkg::M_LOW;
              half_q <= 4'h0;
            end else if (fifo_in_ready) begin
              st_q <= spc_pkg::M_IDLE;
              half_q <= 4'h0;
            end
          end
          spc_pkg::M_FAULT: begin
            if (!fault_q) begin
              st_q <= spc_pkg::M_IDLE;
            end
          end
          default: begin
            st_q <= spc_pkg::M_IDLE;
          end
        endcase
      end
    end
  end

  assign slv_reload = slv_act && !slv_start && rise &&
    (bit_q == spc_pkg::LAST_BIT);

  // shared shift register, left shift, msb first
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      shreg_q <= spc_pkg::TX_IDLE_WORD;
      bit_q <= 3'h0;
    end else if (CE) begin
      if (master_q) begin
        if (mst_start) begin
          shreg_q <= word_in;
          bit_q <= 3'h0;
        end else if ((st_q == spc_pkg::M_HIGH) && half_done &&
                     (bit_q != spc_pkg::LAST_BIT || fifo_in_ready)) begin
          shreg_q <= {shreg_q[6:0], miso_s};
          bit_q <= bit_q + 3'h1;
        end
      end else if (slv_start) begin
        shreg_q <= word_in;
        bit_q <= 3'h0;
      end else if (slv_act && rise) begin
        if (bit_q == spc_pkg::LAST_BIT) begin
          shreg_q <= word_in;
        end else begin
          shreg_q <= {shreg_q[6:0], mosi_s};
        end
        bit_q <= bit_q + 3'h1;
      end
    end
  end

  // slave output bit changes on the falling clock
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      miso_q <= 1'b0;
    end else if (CE) begin
      if (slv_start) begin
        miso_q <= word_in[7];
      end else if (slv_act && fall) begin
        miso_q <= shreg_q[7];
      end
    end
  end

  assign fifo_in_valid = mst_last || slv_reload;
  assign fifo_in_data = {shreg_q[6:0], master_q ? miso_s : mosi_s};

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      overrun_q <= 1'b0;
    end else if (CE) begin
      overrun_q <= slv_reload && !fifo_in_ready;
    end
  end

  assign RX_OVERRUN = overrun_q;
  spc_fifo #(
    .W(spc_pkg::WORD_W),
    .DEPTH(spc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK_SYS),
    .rst(RST),
    .ce(CE),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .out_data(RX_DATA)
  );

  // serial-port direction of each line
  assign mst_drive = master_q && !fault_q;
  always_comb begin
    spi_oe_n = spc_pkg::LINE_OE_N_RST;
    spi_out = spc_pkg::LINE_OUT_RST;
    spi_oe_n[spc_pkg::IDX_LINE_FOUR] = !mst_drive;
    spi_out[spc_pkg::IDX_LINE_FOUR] = st_q == spc_pkg::M_HIGH;
    spi_oe_n[spc_pkg::IDX_LINE_FIVE] = !mst_drive;
    spi_out[spc_pkg::IDX_LINE_FIVE] = shreg_q[7];
    spi_oe_n[spc_pkg::IDX_LINE_SIX] = !slv_act;
    spi_out[spc_pkg::IDX_LINE_SIX] = miso_q;
  end

  // pin drivers; select line left undriven in serial function
  generate
    for (genvar i = 0; i < spc_pkg::LINES; i++) begin : g_line
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          LINE_OE_N[i] <= spc_pkg::LINE_OE_N_RST[i];
          LINE_OUT[i] <= spc_pkg::LINE_OUT_RST[i];
        end else if (CE) begin
          if (pin_gpio_q[i]) begin
            LINE_OE_N[i] <= !GPIO_DIR[i];
            LINE_OUT[i] <= GPIO_OUT[i];
          end else begin
            LINE_OE_N[i] <= spi_oe_n[i];
            LINE_OUT[i] <= spi_out[i];
          end
        end
      end
    end
  endgenerate

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST || !CE);
  sequence s_enter_high;
    (st_q == spc_pkg::M_LOW) ##1 (st_q == spc_pkg::M_HIGH);
  endsequence
  sequence s_unsel_slave;
    !master_q && !slv_act;
  endsequence

  chk_miso_release: assert property (
    s_unsel_slave ##0 !pin_gpio_q[2] |=> LINE_OE_N[2])
    else $error("unselected slave drives data-out line");
  chk_miso_slave: assert property (
    slv_act && !pin_gpio_q[2] |=>
      !LINE_OE_N[2] && LINE_OUT[2] == $past(miso_q))
    else $error("selected slave does not drive data-out line");
  chk_miso_master: assert property (
    master_q && !pin_gpio_q[2] |=> LINE_OE_N[2])
    else $error("master drives its data-in line");
  chk_mosi_setup: assert property (
    s_enter_high |-> $past(st_q, 6) == spc_pkg::M_LOW)
    else $error("data set up less than half a clock period");
  chk_mosi_stable: assert property (
    (st_q == spc_pkg::M_LOW) ##1 (st_q != spc_pkg::M_IDLE) |->
      $stable(shreg_q[7]))
    else $error("master data changed before capture edge");
  chk_master_clock: assert property (
    mst_drive && !pin_gpio_q[0] && !pin_gpio_q[1] |=>
      !LINE_OE_N[0] && !LINE_OE_N[1])
    else $error("master does not drive clock and data-out");
  chk_slave_clock: assert property (
    !master_q && !pin_gpio_q[0] |=> LINE_OE_N[0])
    else $error("slave drives the serial clock");
  chk_mode_fault: assert property (
    fault_set |=> fault_q && st_q == spc_pkg::M_FAULT ##1
      (LINE_OE_N[0] || pin_gpio_q[0]))
    else $error("contention not flagged or drivers kept on");
  chk_unsel_hold: assert property (
    s_unsel_slave |=> $stable(shreg_q) && $stable(bit_q))
    else $error("unselected slave changed receive state");
  chk_gpio_dir: assert property (
    1'b1 |=> ((LINE_OE_N ^ ~$past(GPIO_DIR)) & $past(pin_gpio_q)) == 4'h0)
    else $error("general I/O direction not followed");
  chk_select_input: assert property (
    !pin_gpio_q[3] |=> LINE_OE_N[3])
    else $error("select line driven in serial function");
  chk_reset_spi: assert property (@(posedge CLK_SYS) disable iff (1'b0)
    RST |=> pin_gpio_q == 4'h0 && LINE_OE_N == 4'hF)
    else $error("lines not in serial function after reset");
endmodule

// ### core/spc_sync.sv
module spc_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
    end else if (ce) begin
      s1_q <= d;
      s2_q <= s1_q;
    end
  end

  assign q = s2_q;
endmodule

// ### verification/spc_peer.sv
module spc_peer (
  input wire logic [3:0] line,
  output logic [3:0] pen,
  output logic [3:0] pout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic slv;
  logic [7:0] s_tx;
  logic [7:0] s_rx;
  int bad;
  realtime t_chg;
  initial begin
    pen = 4'h8;
    pout = 4'h8;
    slv = 1'b0;
    s_tx = 8'h00;
    s_rx = 8'h00;
    bad = 0;
    t_chg = 0.0;
  end
  // slave side, mode 0: capture on rise, shift out on fall
  always @(line[1]) t_chg = $realtime;
  always @(posedge line[0]) if (slv) begin
    if ($realtime - t_chg < 55.0) bad++;
    s_rx = {s_rx[6:0], line[1]};
  end
  always @(negedge line[0]) if (slv) begin
    s_tx = {s_tx[6:0], 1'b0};
    pout[2] = s_tx[7];
  end
  task automatic arm(input logic [7:0] w);
    s_tx = w;
    pout[2] = w[7];
    pen[2] = 1'b1;
    slv = 1'b1;
  endtask
  task automatic pins(input logic [3:0] e, input logic [3:0] v);
    slv = 1'b0;
    pen = e;
    pout = v;
  endtask
  // master side: clock stands low outside frames
  task automatic mxfer(input logic [7:0] tx, output logic [7:0] rx);
    pout[1:0] = {tx[7], 1'b0};
    pen[1:0] = 2'b11;
    #100 pout[3] = 1'b0;
    #250;
    for (int i = 7; i >= 0; i--) begin
      pout[1] = tx[i];
      #62.5 pout[0] = 1'b1;
      rx[i] = line[2];
      #62.5 pout[0] = 1'b0;
    end
    #100 pout[3] = 1'b1;
    #100 pen[1:0] = 2'b00;
    #100;
  endtask
endmodule

// ### verification/test_spi_port_pin_interface.sv
module test_spi_port_pin_interface;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic MASTER_MODE = 1'b0;
  logic [3:0] GPIO_SEL = 4'h0;
  logic [3:0] GPIO_DIR = 4'hF;
  logic [3:0] GPIO_OUT = 4'hF;
  logic FAULT_CLR = 1'b0;
  logic [7:0] TX_DATA = 8'h00;
  logic TX_VALID = 1'b0;
  logic RX_READY = 1'b0;
  logic CE = 1'b1;
  logic [3:0] GPIO_IN, LINE_OUT, LINE_OE_N, pen, pout, line;
  logic MODE_FAULT, TX_READY, RX_VALID, RX_OVERRUN;
  logic tog = 1'b0;
  logic [7:0] RX_DATA, got;
  int miscompares = 0;
  int tests_run = 0;
  int ovr = 0;
  always #5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) tog <= ~tog;
  always @(posedge CLK_SYS) if (RX_OVERRUN === 1'b1) ovr++;
  // wire level: device first, then peer, else a floating pattern
  always_comb for (int i = 0; i < 4; i++)
    line[i] = !LINE_OE_N[i] ? LINE_OUT[i] : pen[i] ? pout[i] : tog ^ i[0];
  spc_port spc_port_inst (.CLK_SYS, .RST, .CE, .MASTER_MODE,
    .GPIO_SEL, .GPIO_DIR, .GPIO_OUT, .GPIO_IN, .FAULT_CLR, .MODE_FAULT,
    .TX_DATA, .TX_VALID, .TX_READY, .RX_DATA, .RX_VALID, .RX_READY,
    .RX_OVERRUN, .LINE_IN(line), .LINE_OUT, .LINE_OE_N);
  spc_peer spc_peer_inst (.line(line), .pen(pen), .pout(pout));
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic give_up();
    miscompares++;
    final_report();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic load_tx(input logic [7:0] w);
    @(posedge CLK_SYS);
    TX_DATA <= w;
    TX_VALID <= 1'b1;
    @(posedge CLK_SYS);
    TX_VALID <= 1'b0;
  endtask
  task automatic pop_check(input logic [7:0] e);
    int n;
    n = 0;
    #1;
    while (RX_VALID !== 1'b1) begin
      if (n++ > 3000) give_up();
      tick(1);
    end
    check(RX_DATA, e);
    @(posedge CLK_SYS);
    RX_READY <= 1'b1;
    @(posedge CLK_SYS);
    RX_READY <= 1'b0;
  endtask
  task automatic t_reset();
    tick(4);
    check(LINE_OE_N, 4'hF);
    check(LINE_OUT, 4'h0);
    check({MODE_FAULT, RX_VALID, TX_READY}, 8'h01);
  endtask
  task automatic t_slave();
    tick(200);
    check(RX_VALID, 1'b0);
    check(LINE_OE_N[2], 1'b1);
    load_tx(8'hA5);
    spc_peer_inst.mxfer(8'h3C, got);
    check(got, 8'hA5);
    pop_check(8'h3C);
    check(LINE_OE_N, 4'hF);
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 17; i++) begin
      spc_peer_inst.mxfer(8'(i + 16), got);
    end
    check(got, spc_pkg::TX_IDLE_WORD);
    check(8'(ovr), 8'h01);
    for (int i = 0; i < 16; i++) pop_check(8'(i + 16));
    tick(4);
    check(RX_VALID, 1'b0);
  endtask
  task automatic t_master();
    @(posedge CLK_SYS);
    MASTER_MODE <= 1'b1;
    tick(3);
    spc_peer_inst.arm(8'h96);
    load_tx(8'h5A);
    pop_check(8'h96);
    check(spc_peer_inst.s_rx, 8'h5A);
    check(8'(spc_peer_inst.bad), 8'h00);
    check(LINE_OE_N, 4'hC);
  endtask
  task automatic t_fault();
    int n;
    load_tx(8'hFF);
    tick(30);
    spc_peer_inst.pins(4'h8, 4'h0);
    n = 0;
    while (MODE_FAULT !== 1'b1) begin
      if (n++ > 20) give_up();
      tick(1);
    end
    tick(1);
    check(LINE_OE_N[1:0], 2'b11);
    spc_peer_inst.pins(4'h8, 4'h8);
    tick(200);
    check(RX_VALID, 1'b0);
    @(posedge CLK_SYS);
    FAULT_CLR <= 1'b1;
    @(posedge CLK_SYS);
    FAULT_CLR <= 1'b0;
    tick(2);
    check(MODE_FAULT, 1'b0);
  endtask
  task automatic t_gpio();
    spc_peer_inst.pins(4'h0, 4'h0);
    @(posedge CLK_SYS);
    MASTER_MODE <= 1'b0;
    GPIO_SEL <= 4'hF;
    GPIO_OUT <= 4'hA;
    tick(3);
    check(LINE_OE_N, 4'h0);
    check(LINE_OUT, 4'hA);
    spc_peer_inst.pins(4'h9, 4'h9);
    @(posedge CLK_SYS);
    GPIO_DIR <= 4'h6;
    tick(5);
    check(LINE_OE_N, 4'h9);
    check(GPIO_IN, 4'hB);
    @(posedge CLK_SYS);
    CE <= 1'b0;
    GPIO_DIR <= 4'hF;
    tick(4);
    check(LINE_OE_N, 4'h9);
    @(posedge CLK_SYS);
    CE <= 1'b1;
    tick(3);
    check(LINE_OE_N, 4'h0);
  endtask
  initial begin
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_reset();
    t_slave();
    t_fifo();
    t_master();
    t_fault();
    t_gpio();
    final_report();
  end
endmodule
